// File: common/ssic_pkg.sv
// Purpose: shared constants and types for the synchronous memory input control block
// Assumes: 32-bit AHB-Lite register bus, word-aligned registers
// Notes:   all offsets and field positions, and the control reset value, live here
package ssic_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W_DEF  = 18;
    localparam int LANES_DEF   = 4;
    localparam int BURST_W     = 2;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] REG_CTRL_OFS   = 12'h000;
    localparam logic [11:0] REG_STATUS_OFS = 12'h004;
    localparam logic [11:0] REG_ADDR_OFS   = 12'h008;
    localparam logic [11:0] REG_COUNT_OFS  = 12'h00c;
    localparam int          REG_DEC_W      = 12;

    // control fields
    localparam int CTRL_ORDER_FORCE_BIT = 0;
    localparam int CTRL_ORDER_VALUE_BIT = 1;
    localparam int CTRL_CLR_COUNT_BIT   = 2;
    localparam int CTRL_W               = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

    // status fields
    localparam int STAT_ACTIVE_BIT   = 0;
    localparam int STAT_WRITE_BIT    = 1;
    localparam int STAT_COUNT_LSB    = 2;
    localparam int STAT_ILEAVE_BIT   = 4;
    localparam int STAT_STRAP_BIT    = 5;
    localparam int STAT_HOLD_BIT     = 6;
    localparam int STAT_LANES_LSB    = 8;

    // AHB encodings
    localparam logic [1:0] HTRANS_IDLE   = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    // access kinds
    typedef enum logic [1:0] {
        SSIC_IDLE,
        SSIC_READ,
        SSIC_WRITE
    } ssic_op_type;

endpackage : ssic_pkg

// File: hdl/ssic_strap_sync.sv
// Purpose: two-stage synchroniser for the static burst-order strap
// Assumes: strap changes only while the system is quiet
// Notes:   only the second stage is read outside
`timescale 1ns/10ps
`default_nettype none
module ssic_strap_sync
    import ssic_pkg::*;
(
    input  wire logic clk_sys,   // system clock
    input  wire logic rst,       // async reset, active high
    input  wire logic strap_in,  // raw strap pin
    output logic      strap_out  // synchronised strap
);

    typedef struct packed {
        logic meta;
        logic sync;
    } ssic_sync_state_type;

    ssic_sync_state_type s_q;
    ssic_sync_state_type s_d;

    always_comb begin
        s_d      = s_q;
        s_d.meta = strap_in;
        s_d.sync = s_q.meta;
    end

    // open strap reads high, so reset to interleaved
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '{meta: 1'b1, sync: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign strap_out = s_q.sync;

endmodule // ssic_strap_sync
`default_nettype wire

// File: hdl/ssic_burst_seq.sv
// Purpose: next burst location within a four-location group
// Assumes: step index counts 0..3 from the loaded start
// Notes:   pure combinational; never touches upper address bits
`timescale 1ns/10ps
`default_nettype none
module ssic_burst_seq
    import ssic_pkg::*;
(
    input  wire logic [BURST_W-1:0] start,      // loaded low address bits
    input  wire logic [BURST_W-1:0] step_idx,   // current step index
    input  wire logic               interleave, // 1 interleaved, 0 linear
    output logic      [BURST_W-1:0] next_idx,   // step index after advance
    output logic      [BURST_W-1:0] next_loc    // low bits of next location
);

    always_comb begin
        next_idx = step_idx + 2'h1;
        if (interleave) begin
            next_loc = start ^ next_idx;
        end else begin
            next_loc = start + next_idx;
        end
    end

endmodule // ssic_burst_seq
`default_nettype wire

// File: hdl/ssic_top.sv
// Purpose: input capture and access control of a flow-through burst memory
// Assumes: the controller drives the memory pins from clk_sys, so they need no synchroniser
// Notes:   registers over AHB-Lite, zero wait states, always OKAY
//
// How it works
// - Address inputs are captured on qualified, selected load edges and pick one storage location.
// - The two lowest address bits seed a two-bit burst counter that walks the burst.
// - Each byte write select is active low and sampled on the rising edge.
// - A byte lane is written only when its select is low and the access, set by the write strobe at load, is a write.
// - The write strobe is sampled only on edges where the clock qualifier is low.
// - Advance/load high on a qualified edge steps the burst counter to the next location while an access is in progress.
// - Advance/load low on a qualified edge loads the presented address as a new access if selected, else ends the access.
// - Edges with the clock qualifier high change no access state; they only set the hold flag and end the fire pulse.
// - One clock registers every synchronous control, address and write-select input.
// - A high qualifier freezes state and extends the previous cycle without deselecting.
// - The device is selected only with first select low, second high and third low.
// - With the order force bit clear, the burst-order strap low gives linear order, high or open gives interleaved.
`timescale 1ns/10ps
`default_nettype none
module ssic_top
    import ssic_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int LANES  = LANES_DEF
)(
    input  wire logic              clk_sys,          // system clock, 200 MHz
    input  wire logic              rst,              // async reset, active high
    // memory pins from the controller
    input  wire logic [ADDR_W-1:0] mem_addr,         // address, low two bits burst start
    input  wire logic [LANES-1:0]  lane_write_sel_n, // byte write selects, active low
    input  wire logic              write_strobe_n,   // write strobe, active low
    input  wire logic              step_or_load,     // 1 advance, 0 load
    input  wire logic              clock_qualifier_n,// clock qualifier, active low
    input  wire logic              select_first_n,   // chip select one, active low
    input  wire logic              select_second,    // chip select two, active high
    input  wire logic              select_third_n,   // chip select three, active low
    input  wire logic              burst_order_strap,// 0 linear, 1 interleaved
    // access towards the array
    output logic      [ADDR_W-1:0] acc_addr,         // current location
    output logic      [BURST_W-1:0] acc_burst,       // burst counter value
    output logic                   acc_active,       // an access is in progress
    output logic                   acc_write,        // current access is a write
    output logic      [LANES-1:0]  acc_lane_we,      // per-lane write enables
    output logic                   acc_fire,         // pulse per qualified active edge
    // AHB-Lite slave
    input  wire logic              hsel,             // slave select
    input  wire logic [31:0]       haddr,            // byte address
    input  wire logic [1:0]        htrans,           // transfer type
    input  wire logic              hwrite,           // write transfer
    input  wire logic [2:0]        hsize,            // transfer size
    input  wire logic [31:0]       hwdata,           // write data
    input  wire logic              hready,           // bus ready
    output logic                   hreadyout,        // slave ready
    output logic                   hresp,            // response
    output logic      [31:0]       hrdata            // read data
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0]  addr;
        logic [BURST_W-1:0] start;
        logic [BURST_W-1:0] step_idx;
        logic [BURST_W-1:0] loc;
        ssic_op_type        op;
        logic [LANES-1:0]   lane_we;
        logic               fire;
        logic               hold;
        logic [CTRL_W-1:0]  ctrl;
        logic [31:0]        load_count;
        logic               dph_write;
        logic [REG_DEC_W-1:0] dph_addr;
        logic [31:0]        rdata;
    } ssic_state_type;

    ssic_state_type s_q;
    ssic_state_type s_d;

    logic               strap_sync;
    logic               interleave;
    logic               selected;
    logic               qualified;
    logic [BURST_W-1:0] nxt_idx;
    logic [BURST_W-1:0] nxt_loc;
    logic               ahb_take;
    logic [31:0]        status_word;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] read_mux(input logic [REG_DEC_W-1:0] ofs,
                                             input logic [CTRL_W-1:0]    ctrl,
                                             input logic [31:0]          status,
                                             input logic [ADDR_W-1:0]    addr,
                                             input logic [31:0]          count);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (ofs)
            REG_CTRL_OFS:   r[CTRL_W-1:0] = ctrl;
            REG_STATUS_OFS: r = status;
            REG_ADDR_OFS:   r[ADDR_W-1:0] = addr;
            REG_COUNT_OFS:  r = count;
            default:        r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    ssic_strap_sync u_strap (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .strap_in  (burst_order_strap),
        .strap_out (strap_sync)
    );

    ssic_burst_seq u_seq (
        .start      (s_q.start),
        .step_idx   (s_q.step_idx),
        .interleave (interleave),
        .next_idx   (nxt_idx),
        .next_loc   (nxt_loc)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // software may force the burst order over the strap
    assign interleave = s_q.ctrl[CTRL_ORDER_FORCE_BIT] ?
                        s_q.ctrl[CTRL_ORDER_VALUE_BIT] : strap_sync;
    assign selected   = ~select_first_n & select_second & ~select_third_n;
    assign qualified  = ~clock_qualifier_n;
    assign ahb_take   = hsel & hready & htrans[1];

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STAT_ACTIVE_BIT] = (s_q.op != SSIC_IDLE);
        status_word[STAT_WRITE_BIT]  = (s_q.op == SSIC_WRITE);
        status_word[STAT_COUNT_LSB +: BURST_W] = s_q.loc;
        status_word[STAT_ILEAVE_BIT] = interleave;
        status_word[STAT_STRAP_BIT]  = strap_sync;
        status_word[STAT_HOLD_BIT]   = s_q.hold;
        status_word[STAT_LANES_LSB +: LANES] = s_q.lane_we;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        s_d.fire = 1'b0;
        s_d.hold = ~qualified;

        // memory side: all but the hold flag and fire pulse waits for a qualified edge
        if (qualified) begin
            s_d.fire = 1'b1;
            if (!step_or_load) begin
                if (selected) begin
                    s_d.addr     = mem_addr;
                    s_d.start    = mem_addr[BURST_W-1:0];
                    s_d.loc      = mem_addr[BURST_W-1:0];
                    s_d.step_idx = 2'h0;
                    s_d.load_count = s_q.load_count + 32'h0000_0001;
                    if (!write_strobe_n) begin
                        s_d.op      = SSIC_WRITE;
                        s_d.lane_we = ~lane_write_sel_n;
                    end else begin
                        s_d.op      = SSIC_READ;
                        s_d.lane_we = '0;
                    end
                end else begin
                    s_d.op      = SSIC_IDLE;
                    s_d.lane_we = '0;
                    s_d.fire    = 1'b0;
                end
            end else if (s_q.op != SSIC_IDLE) begin
                s_d.step_idx = nxt_idx;
                s_d.loc      = nxt_loc;
                s_d.addr     = {s_q.addr[ADDR_W-1:BURST_W], nxt_loc};
                if (s_q.op == SSIC_WRITE) begin
                    s_d.lane_we = ~lane_write_sel_n;
                end else begin
                    s_d.lane_we = '0;
                end
            end else begin
                // advance with no access in progress does nothing
                s_d.fire = 1'b0;
            end
        end

        // bus side: data phase of a taken write
        if (s_q.dph_write) begin
            if (s_q.dph_addr == REG_CTRL_OFS) begin
                s_d.ctrl = hwdata[CTRL_W-1:0];
                if (hwdata[CTRL_CLR_COUNT_BIT]) begin
                    s_d.load_count = 32'h0000_0000;
                end
            end
        end

        // bus side: address phase
        s_d.dph_write = 1'b0;
        if (ahb_take) begin
            s_d.dph_addr  = haddr[REG_DEC_W-1:0];
            s_d.dph_write = hwrite;
            if (!hwrite) begin
                s_d.rdata = read_mux(haddr[REG_DEC_W-1:0], s_q.ctrl, status_word,
                                     s_q.addr, s_q.load_count);
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q.addr       <= '0;
            s_q.start      <= 2'h0;
            s_q.step_idx   <= 2'h0;
            s_q.loc        <= 2'h0;
            s_q.op         <= SSIC_IDLE;
            s_q.lane_we    <= '0;
            s_q.fire       <= 1'b0;
            s_q.hold       <= 1'b0;
            s_q.ctrl       <= CTRL_RESET;
            s_q.load_count <= 32'h0000_0000;
            s_q.dph_write  <= 1'b0;
            s_q.dph_addr   <= '0;
            s_q.rdata      <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign acc_addr    = s_q.addr;
    assign acc_burst   = s_q.loc;
    assign acc_active  = (s_q.op != SSIC_IDLE);
    assign acc_write   = (s_q.op == SSIC_WRITE);
    assign acc_lane_we = s_q.lane_we;
    assign acc_fire    = s_q.fire;
    assign hreadyout   = 1'b1;
    assign hresp       = HRESP_OKAY;
    assign hrdata      = s_q.rdata;

endmodule // ssic_top
`default_nettype wire

// File: testbench/ssic_top_sva.sv
// Purpose: concurrent checks on the capture and burst outputs
// Assumes: memory pins are synchronous to clk_sys
// Notes:   bound onto every ssic_top
`timescale 1ns/10ps
`default_nettype none
module ssic_top_sva
    import ssic_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int LANES  = LANES_DEF
)(
    input wire logic               clk_sys,           // clock
    input wire logic               rst,               // reset
    input wire logic [ADDR_W-1:0]  mem_addr,          // address
    input wire logic [LANES-1:0]   lane_write_sel_n,  // lane selects
    input wire logic               write_strobe_n,    // strobe
    input wire logic               step_or_load,      // advance/load
    input wire logic               clock_qualifier_n, // qualifier
    input wire logic               select_first_n,    // select one
    input wire logic               select_second,     // select two
    input wire logic               select_third_n,    // select three
    input wire logic [ADDR_W-1:0]  acc_addr,          // location
    input wire logic [BURST_W-1:0] acc_burst,         // burst location
    input wire logic               acc_active,        // active
    input wire logic               acc_write,         // write
    input wire logic [LANES-1:0]   acc_lane_we,       // lane enables
    input wire logic               acc_fire           // edge pulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire ld  = !clock_qualifier_n && !step_or_load;
    wire sel = !select_first_n && select_second && !select_third_n;
    wire stp = !clock_qualifier_n && step_or_load;
    a_hold_freeze: assert property (clock_qualifier_n |=>
        $stable(acc_addr) && $stable(acc_lane_we) && $stable(acc_active) && !acc_fire)
        else $error("held edge changed state");
    a_load_addr: assert property (ld && sel |=> acc_active && acc_fire &&
        acc_addr == $past(mem_addr) && acc_burst == $past(mem_addr[BURST_W-1:0]))
        else $error("load did not capture address");
    a_write_lanes: assert property (ld && sel && !write_strobe_n |=>
        acc_write && acc_lane_we == ~$past(lane_write_sel_n))
        else $error("write lanes wrong");
    a_read_lanes: assert property (ld && sel && write_strobe_n |=>
        !acc_write && acc_lane_we == '0)
        else $error("read enabled a lane");
    a_deselect_load: assert property (ld && !sel |=>
        !acc_active && !acc_fire && acc_lane_we == '0)
        else $error("unselected load started access");
    a_step_wrap: assert property (stp && acc_active |=> acc_fire && $stable(acc_write) &&
        $stable(acc_addr[ADDR_W-1:BURST_W]) && acc_burst != $past(acc_burst))
        else $error("advance step wrong");
    a_idle_step: assert property (stp && !acc_active |=> !acc_active && !acc_fire)
        else $error("advance while idle acted");
    a_loc_match: assert property (acc_addr[BURST_W-1:0] == acc_burst)
        else $error("location and counter differ");
endmodule // ssic_top_sva
bind ssic_top ssic_top_sva #(.ADDR_W(ADDR_W), .LANES(LANES)) u_sva (
    .clk_sys, .rst, .mem_addr, .lane_write_sel_n, .write_strobe_n, .step_or_load,
    .clock_qualifier_n, .select_first_n, .select_second, .select_third_n,
    .acc_addr, .acc_burst, .acc_active, .acc_write, .acc_lane_we, .acc_fire
);
`default_nettype wire

// File: testbench/ssic_ctrl_model.sv
// Purpose: controller-side model driving the memory pins
// Assumes: requests change by non-blocking assignment at a rising edge
// Notes:   without a request the qualifier rises and other pins scramble
`timescale 1ns/10ps
`default_nettype none
module ssic_ctrl_model
    import ssic_pkg::*;
#(
    parameter int AW = ADDR_W_DEF
)(
    input  wire logic          clk_sys,           // clock
    input  wire logic          rst,               // reset
    input  wire logic          go,                // request stands
    input  wire logic [AW-1:0] rq_addr,           // address
    input  wire logic [3:0]    rq_ln,             // lane selects
    input  wire logic          rq_wr,             // write wanted
    input  wire logic          rq_adv,            // advance wanted
    input  wire logic [2:0]    rq_sel,            // select levels
    output logic      [AW-1:0] mem_addr,          // address pins
    output logic      [3:0]    lane_write_sel_n,  // lane pins
    output logic               write_strobe_n,    // strobe pin
    output logic               step_or_load,      // advance/load pin
    output logic               clock_qualifier_n, // qualifier pin
    output logic      [2:0]    sel_pins           // select pins
);
    logic desel_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            desel_q <= 1'b0;
        else if (go && !step_or_load)
            desel_q <= (rq_sel != 3'b010);
    end
    assign clock_qualifier_n = ~go;
    assign mem_addr          = go ? rq_addr : ~rq_addr;
    assign lane_write_sel_n  = go ? rq_ln : ~rq_ln;
    assign write_strobe_n    = go ? ~rq_wr : rq_wr;
    // fresh load forced after a deselect
    assign step_or_load      = go ? (rq_adv & ~desel_q) : ~rq_adv;
    assign sel_pins          = go ? rq_sel : ~rq_sel;
endmodule // ssic_ctrl_model
`default_nettype wire

// File: testbench/ssic_top_tb.sv
// Purpose: self-checking bench for ssic_top
// Assumes: memory pins come from the controller model
// Notes:   outputs compared at the falling edge after each taking edge
`timescale 1ns/10ps
`default_nettype none
module ssic_top_tb
    import ssic_pkg::*;
;
    localparam int            AW    = ADDR_W_DEF;
    localparam int            EW    = AW + 9;
    localparam logic [2:0]    SEL   = 3'b010;
    localparam logic [EW-1:0] MPART = EW'(7'h5f);
    logic          clk_sys = 1'b0, rst = 1'b1, go = 1'b0, rq_wr = 1'b0, rq_adv = 1'b0;
    logic          ck = 1'b0, ck_d = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [AW-1:0] rq_addr = '0, a, b, c, mem_addr, acc_addr;
    logic [3:0]    rq_ln = '0, lane_write_sel_n, acc_lane_we;
    logic [2:0]    rq_sel = '0, sel_pins, hsize = 3'h2;
    logic [EW-1:0] ex = '0, ex_d = '0, mk = '1, mk_d = '1;
    logic [31:0]   haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]    htrans = HTRANS_IDLE, acc_burst;
    logic          write_strobe_n, step_or_load, clock_qualifier_n, hreadyout, hresp;
    logic          acc_active, acc_write, acc_fire, burst_order_strap = 1'b0;
    int            fail_count = 0, cmp_count = 0, i;
    wire  [EW-1:0] got = {acc_addr, acc_burst, acc_active, acc_write, acc_lane_we, acc_fire};
    ssic_ctrl_model #(.AW(AW)) u_ctrl (
        .clk_sys, .rst, .go, .rq_addr, .rq_ln, .rq_wr, .rq_adv, .rq_sel, .mem_addr,
        .lane_write_sel_n, .write_strobe_n, .step_or_load, .clock_qualifier_n, .sel_pins
    );
    ssic_top dut (
        .clk_sys, .rst, .mem_addr, .lane_write_sel_n, .write_strobe_n, .step_or_load,
        .clock_qualifier_n, .select_first_n(sel_pins[2]), .select_second(sel_pins[1]),
        .select_third_n(sel_pins[0]), .burst_order_strap, .acc_addr, .acc_burst,
        .acc_active, .acc_write, .acc_lane_we, .acc_fire, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata
    );
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        ck_d <= ck;
        ex_d <= ex;
        mk_d <= mk;
    end
    always @(negedge clk_sys) if (ck_d) cmp_mem(got & mk_d, ex_d & mk_d);
    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic cmp_mem(input logic [EW-1:0] g, input logic [EW-1:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    function automatic logic [EW-1:0] ev(input logic [AW-1:0] ad, input logic act, w,
                                         input logic [3:0] we, input logic f);
        return {ad, ad[1:0], act, w, we, f};
    endfunction
    task automatic op(input logic [AW-1:0] ad, input logic [3:0] ln, input logic w, adv,
                      input logic [2:0] sl, input logic [EW-1:0] e, input logic full);
        @(posedge clk_sys);
        go <= 1'b1;
        rq_addr <= ad;
        rq_ln <= ln;
        rq_wr <= w;
        rq_adv <= adv;
        rq_sel <= sl;
        ex <= e;
        ck <= 1'b1;
        mk <= full ? '1 : MPART;
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            go <= 1'b0;
            ck <= 1'b1;
            ex[0] <= 1'b0;
        end
    endtask
    task automatic ahb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {20'h00000, ad};
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [11:0] ad, input logic [31:0] e);
        ahb(1'b0, ad, 32'h0);
        cmp_reg(rd, e);
        cmp_reg({31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(REG_CTRL_OFS, 32'h0);
        idle(3);
        op(18'h0, 4'hf, 1'b0, 1'b1, SEL, ev('0, 0, 0, 4'h0, 0), 1'b1);
        a = 18'h12345;
        op(a, 4'h5, 1'b1, 1'b0, SEL, ev(a, 1, 1, 4'ha, 1), 1'b1);
        for (i = 1; i < 5; i++) begin
            op(~a, i[3:0], 1'b0, 1'b1, SEL, ev({a[AW-1:2], 2'(a[1:0] + i)}, 1, 1, ~i[3:0], 1),
               1'b1);
        end
        idle(2);
        ahb(1'b1, REG_CTRL_OFS, 32'h3);
        rd_chk(REG_CTRL_OFS, 32'h3);
        b = 18'h2abc6;
        op(b, 4'h0, 1'b0, 1'b0, SEL, ev(b, 1, 0, 4'h0, 1), 1'b1);
        for (i = 1; i < 5; i++) begin
            op(~b, 4'h0, 1'b1, 1'b1, SEL, ev({b[AW-1:2], b[1:0] ^ i[1:0]}, 1, 0, 4'h0, 1),
               1'b1);
        end
        c = 18'h0f0f3;
        for (i = 0; i < 8; i++) begin
            if (i != 2) op(c, 4'h0, 1'b1, 1'b0, i[2:0], ev(c, 0, 0, 4'h0, 0), 1'b0);
        end
        op(c, 4'h0, 1'b0, 1'b1, SEL, ev(c, 1, 0, 4'h0, 1), 1'b1);
        idle(1);
        rd_chk(REG_ADDR_OFS, 32'(c));
        rd_chk(REG_STATUS_OFS, 32'h5d);
        rd_chk(REG_COUNT_OFS, 32'h3);
        rd_chk(12'h010, 32'h0);
        ahb(1'b1, REG_ADDR_OFS, 32'hffffffff);
        rd_chk(REG_ADDR_OFS, 32'(c));
        ahb(1'b1, REG_CTRL_OFS, 32'h4);
        rd_chk(REG_COUNT_OFS, 32'h0);
        rd_chk(REG_CTRL_OFS, 32'h0);
        // strap high with no override: interleaved stepping once the strap has synchronised
        burst_order_strap <= 1'b1;
        idle(2);
        op(~c, 4'h0, 1'b0, 1'b1, SEL, ev({c[AW-1:2], c[1:0] ^ 2'h1}, 1, 0, 4'h0, 1),
           1'b1);
        idle(1);
        rd_chk(REG_STATUS_OFS, 32'h79);
        summarize();
    end
endmodule // ssic_top_tb
`default_nettype wire
